// File: ptm_defs.vh
// Constants of the periodic timer: offsets, fields, reset values.
// Assumes a 32-bit classic Wishbone slave on a 50 MHz clock.
`ifndef PTM_DEFS_VH
`define PTM_DEFS_VH
// Register byte offsets
`define PTM_OFS_CTRL0 8'h00
`define PTM_OFS_CTRL1 8'h04
`define PTM_OFS_CNT_L 8'h08
`define PTM_OFS_CNT_H 8'h0C
`define PTM_OFS_CMPA_L 8'h10
`define PTM_OFS_CMPA_H 8'h14
`define PTM_OFS_PER_L 8'h18
`define PTM_OFS_PER_H 8'h1C
`define PTM_OFS_STATUS 8'h20
`define PTM_OFS_PRESCALE 8'h24
// Control 0 fields
`define PTM_C0_ENABLE 3
`define PTM_C0_EXT_TICK 4
// Control 1 fields
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_PIN_HI 5
`define PTM_C1_PIN_LO 4
`define PTM_C1_INIT_LVL 3
`define PTM_C1_INVERT 2
`define PTM_C1_CAP_SRC 1
`define PTM_C1_CLR_SEL 0
// Status fields
`define PTM_ST_FLAG_A 0
`define PTM_ST_FLAG_P 1
// Modes
`define PTM_MODE_CMP 2'b00
`define PTM_MODE_CAP 2'b01
`define PTM_MODE_PWM 2'b10
`define PTM_MODE_TMR 2'b11
// Reset values
`define PTM_RST_BYTE 8'h00
`define PTM_RST_CNT 10'h000
`define PTM_RST_PRESCALE 8'h00
`endif

// File: ptm_pin_model.sv
// Far side of the timer pins: pull-up on the output pin, driven clock pin.
// Assumes the bench sets the clock pin level just after clock edges.
`timescale 1ns/1ns
module ptm_pin_model (
  input wire pin_drv_i,
  input wire pin_oe_i,
  input wire ext_lvl_i,
  output wire pin_lvl_o,
  output wire ext_pin_o
);
  // Released pin floats to the pull-up, so no stale drive is seen
  assign pin_lvl_o = pin_oe_i ? pin_drv_i : 1'b1;
  assign ext_pin_o = ext_lvl_i;
endmodule

// File: ptm_timer.v
// 10-bit periodic timer with compare output, capture and PWM.
// Assumes a classic Wishbone master on clk_i; pins are asynchronous.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`include "ptm_defs.vh"
module ptm_timer (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  input wire timer_output_pin_i,
  output wire timer_output_pin_o,
  output wire timer_output_pin_oe_o,
  input wire external_clock_pin_i,
  output wire compare_a_flag_o,
  output wire compare_p_flag_o
);

  // ==========================================================
  // Register decode
  // ==========================================================
  function [3:0] ptm_decode;
    input [7:0] adr;
    begin
      case (adr)
        `PTM_OFS_CTRL0: ptm_decode = 4'h1;
        `PTM_OFS_CTRL1: ptm_decode = 4'h2;
        `PTM_OFS_CNT_L: ptm_decode = 4'h3;
        `PTM_OFS_CNT_H: ptm_decode = 4'h4;
        `PTM_OFS_CMPA_L: ptm_decode = 4'h5;
        `PTM_OFS_CMPA_H: ptm_decode = 4'h6;
        `PTM_OFS_PER_L: ptm_decode = 4'h7;
        `PTM_OFS_PER_H: ptm_decode = 4'h8;
        `PTM_OFS_STATUS: ptm_decode = 4'h9;
        `PTM_OFS_PRESCALE: ptm_decode = 4'hA;
        default: ptm_decode = 4'h0;
      endcase
    end
  endfunction

  reg ack_ff;
  reg [31:0] rdata_ff;
  reg [7:0] ctrl0_ff;
  reg [7:0] ctrl1_ff;
  reg [9:0] cmpa_ff;
  reg [9:0] per_ff;
  reg [9:0] cnt_ff;
  reg [7:0] pre_ff;
  reg [7:0] div_ff;
  reg flag_a_ff;
  reg flag_p_ff;
  reg lvl_ff;
  reg pin_ff;
  reg oe_ff;
  reg en_prev_ff;
  reg [2:0] ext_sync_ff;
  reg [2:0] pin_sync_ff;

  wire [3:0] sel_reg = ptm_decode(adr_i);
  wire bus_req = cyc_i & stb_i;
  // Writes land at the edge where the master sees ack
  wire bus_wr = bus_req & we_i & ack_ff & sel_i[0];

  wire [1:0] mode = {ctrl1_ff[`PTM_C1_MODE_HI], ctrl1_ff[`PTM_C1_MODE_LO]};
  wire [1:0] pin_fn = {ctrl1_ff[`PTM_C1_PIN_HI], ctrl1_ff[`PTM_C1_PIN_LO]};
  wire init_lvl = ctrl1_ff[`PTM_C1_INIT_LVL];
  wire invert = ctrl1_ff[`PTM_C1_INVERT];
  wire clr_sel = ctrl1_ff[`PTM_C1_CLR_SEL];
  wire enable = ctrl0_ff[`PTM_C0_ENABLE];
  wire single_pulse = (mode == `PTM_MODE_PWM) && (pin_fn == 2'b11);

  // ==========================================================
  // Pin synchronisers and edge detect
  // ==========================================================
  // Third stage only keeps the previous value for edge detection
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], external_clock_pin_i};
      pin_sync_ff <= {pin_sync_ff[1:0], timer_output_pin_i};
    end
  end

  wire ext_rise = ext_sync_ff[1] & ~ext_sync_ff[2];
  // Capture trigger from clock pin or output pin
  wire cap_now = ctrl1_ff[`PTM_C1_CAP_SRC] ? ext_sync_ff[1] : pin_sync_ff[1];
  wire cap_old = ctrl1_ff[`PTM_C1_CAP_SRC] ? ext_sync_ff[2] : pin_sync_ff[2];
  wire cap_rise = cap_now & ~cap_old;
  wire cap_fall = ~cap_now & cap_old;
  reg cap_hit;
  always @* begin
    case (pin_fn)
      2'b00: cap_hit = cap_rise;
      2'b01: cap_hit = cap_fall;
      2'b10: cap_hit = cap_rise | cap_fall;
      default: cap_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Timer tick
  // ==========================================================
  // Prescaler stands in for the internal clock choices
  wire div_done = (div_ff == pre_ff);
  wire tick = ctrl0_ff[`PTM_C0_EXT_TICK] ? ext_rise : div_done;

  always @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 8'h00;
    end else if (div_done || !enable) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ==========================================================
  // Comparators
  // ==========================================================
  wire [9:0] cnt_inc = cnt_ff + 10'h001;
  wire at_top = (cnt_ff == 10'h3FF);
  wire match_a = tick && enable && (cnt_inc == cmpa_ff);
  // Zero period means the full 1024-count range
  wire match_p = tick && enable && ((per_ff == 10'h000) ? at_top : (cnt_inc == per_ff));
  wire cmp_like = (mode == `PTM_MODE_CMP) || (mode == `PTM_MODE_TMR);
  wire clr_by_a = cmp_like && clr_sel;
  wire set_fa = cmp_like ? match_a
              : (mode == `PTM_MODE_CAP) ? (enable & cap_hit) : match_a;
  wire set_fp = cmp_like ? (match_p & ~clr_sel) : (mode != `PTM_MODE_PWM || !single_pulse) && match_p;

  // Enable rising edge, software or pin-triggered pulse
  wire sp_trig = single_pulse && ext_rise && !enable;
  wire en_rise = enable && !en_prev_ff;

  // ==========================================================
  // Control registers and flags
  // ==========================================================
  reg [7:0] nxt_ctrl0;
  always @* begin
    nxt_ctrl0 = ctrl0_ff;
    if (bus_wr && sel_reg == 4'h1) begin
      nxt_ctrl0 = {3'b000, dat_i[`PTM_C0_EXT_TICK], dat_i[`PTM_C0_ENABLE], 3'b000};
    end
    if (single_pulse && match_a) begin
      nxt_ctrl0[`PTM_C0_ENABLE] = 1'b0;
    end
    if (sp_trig) begin
      nxt_ctrl0[`PTM_C0_ENABLE] = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_ff <= `PTM_RST_BYTE;
      ctrl1_ff <= `PTM_RST_BYTE;
      pre_ff <= `PTM_RST_PRESCALE;
      per_ff <= `PTM_RST_CNT;
      en_prev_ff <= 1'b0;
      flag_a_ff <= 1'b0;
      flag_p_ff <= 1'b0;
    end else begin
      ctrl0_ff <= nxt_ctrl0;
      en_prev_ff <= enable;
      if (bus_wr && sel_reg == 4'h2) begin
        ctrl1_ff <= dat_i[7:0];
      end
      if (bus_wr && sel_reg == 4'hA) begin
        pre_ff <= dat_i[7:0];
      end
      if (bus_wr && sel_reg == 4'h7) begin
        per_ff[7:0] <= dat_i[7:0];
      end
      if (bus_wr && sel_reg == 4'h8) begin
        per_ff[9:8] <= dat_i[1:0];
      end
      // Set wins over a write-one clear in the same cycle
      flag_a_ff <= set_fa | (flag_a_ff & ~(bus_wr && sel_reg == 4'h9 && dat_i[`PTM_ST_FLAG_A]));
      flag_p_ff <= set_fp | (flag_p_ff & ~(bus_wr && sel_reg == 4'h9 && dat_i[`PTM_ST_FLAG_P]));
    end
  end

  // ==========================================================
  // Compare A register, also the capture latch
  // ==========================================================
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmpa_ff <= `PTM_RST_CNT;
    end else if (mode == `PTM_MODE_CAP && enable && cap_hit) begin
      cmpa_ff <= cnt_ff;
    end else if (bus_wr && sel_reg == 4'h5) begin
      cmpa_ff[7:0] <= dat_i[7:0];
    end else if (bus_wr && sel_reg == 4'h6) begin
      cmpa_ff[9:8] <= dat_i[1:0];
    end
  end

  // ==========================================================
  // Counter
  // ==========================================================
  reg [9:0] nxt_cnt;
  always @* begin
    nxt_cnt = cnt_ff;
    if (en_rise) begin
      nxt_cnt = `PTM_RST_CNT;
    end else if (tick && enable) begin
      if (clr_by_a) begin
        nxt_cnt = match_a ? `PTM_RST_CNT : cnt_inc;
      end else if (single_pulse) begin
        nxt_cnt = cnt_inc;
      end else begin
        nxt_cnt = match_p ? `PTM_RST_CNT : cnt_inc;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= `PTM_RST_CNT;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ==========================================================
  // Output pin
  // ==========================================================
  // Compare-mode level: A matches move it; enable rise loads init_lvl
  reg nxt_lvl;
  always @* begin
    nxt_lvl = lvl_ff;
    if (en_rise) begin
      nxt_lvl = init_lvl;
    end else if (match_a && mode == `PTM_MODE_CMP) begin
      case (pin_fn)
        2'b01: nxt_lvl = 1'b0;
        2'b10: nxt_lvl = 1'b1;
        2'b11: nxt_lvl = ~lvl_ff;
        default: nxt_lvl = lvl_ff;
      endcase
    end
  end

  // PWM is active while the count is below the duty value
  wire pwm_act = enable && (cnt_ff < cmpa_ff);
  reg base;
  reg nxt_oe;
  always @* begin
    base = 1'b0;
    nxt_oe = 1'b1;
    case (mode)
      `PTM_MODE_CMP: base = lvl_ff;
      `PTM_MODE_PWM: begin
        case (pin_fn)
          2'b00: base = ~init_lvl;
          2'b01: base = init_lvl;
          2'b10: base = pwm_act ? init_lvl : ~init_lvl;
          default: base = enable ? init_lvl : ~init_lvl;
        endcase
      end
      default: nxt_oe = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lvl_ff <= 1'b0;
      pin_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      lvl_ff <= nxt_lvl;
      pin_ff <= nxt_oe & (base ^ invert);
      oe_ff <= nxt_oe;
    end
  end

  // ==========================================================
  // Wishbone read and ack
  // ==========================================================
  reg [7:0] nxt_rd;
  always @* begin
    case (sel_reg)
      4'h1: nxt_rd = ctrl0_ff;
      4'h2: nxt_rd = ctrl1_ff;
      4'h3: nxt_rd = cnt_ff[7:0];
      4'h4: nxt_rd = {6'h00, cnt_ff[9:8]};
      4'h5: nxt_rd = cmpa_ff[7:0];
      4'h6: nxt_rd = {6'h00, cmpa_ff[9:8]};
      4'h7: nxt_rd = per_ff[7:0];
      4'h8: nxt_rd = {6'h00, per_ff[9:8]};
      4'h9: nxt_rd = {6'h00, flag_p_ff, flag_a_ff};
      4'hA: nxt_rd = pre_ff;
      default: nxt_rd = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      rdata_ff <= {24'h000000, nxt_rd};
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;
  assign timer_output_pin_o = pin_ff;
  assign timer_output_pin_oe_o = oe_ff;
  assign compare_a_flag_o = flag_a_ff;
  assign compare_p_flag_o = flag_p_ff;

endmodule

// File: ptm_timer_asserts.sv
// Port checks for ptm_timer, bound into every instance.
// Assumes writes use byte lane 0 of a classic Wishbone bus.
`timescale 1ns/1ns
module ptm_timer_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire timer_output_pin_o,
  input wire timer_output_pin_oe_o,
  input wire compare_a_flag_o,
  input wire compare_p_flag_o
);
  // ==========
  // Control shadow
  logic [7:0] ctl_ff;
  logic [2:0] age_ff, en_age_ff;
  wire wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  // Pin and oe lag a control write; judge only once settled
  wire calm = age_ff > 3'h2;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_ff <= 8'h00;
      age_ff <= 3'h0;
      en_age_ff <= 3'h0;
    end else begin
      if (wr && adr_i == 8'h04) begin
        ctl_ff <= dat_i[7:0];
      end
      age_ff <= (wr && adr_i == 8'h04) ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
      en_age_ff <= (wr && adr_i == 8'h00) ? 3'h0 : en_age_ff + {2'h0, en_age_ff != 3'h7};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Properties
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");
  property p_rd_upper; ack_o && !we_i |-> dat_o[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  property p_rd_hi; ack_o && !we_i && adr_i inside {8'h0C, 8'h14, 8'h1C} |-> dat_o[7:2] == 6'h00; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("unused high bits read nonzero");
  property p_free_pin; calm && ctl_ff[6] |-> !timer_output_pin_oe_o; endproperty
  a_free_pin: assert property (p_free_pin) else $error("pin driven in a non-output mode");
  property p_pin_a; ctl_ff[7:6] == 2'b00 && calm && en_age_ff > 3'h3 && $changed(timer_output_pin_o)
    |-> compare_a_flag_o; endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin moved without an A match");
  property p_no_p; ctl_ff[7:6] != 2'b10 && !ctl_ff[6] && ctl_ff[0] && calm && !$past(compare_p_flag_o)
    |-> !compare_p_flag_o; endproperty
  a_no_p: assert property (p_no_p) else $error("P flag raised with clear on A");
  property p_flag_keep; compare_a_flag_o && !(wr && adr_i == 8'h20) |=> compare_a_flag_o; endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("A flag dropped by itself");
endmodule
bind ptm_timer ptm_timer_asserts u_ptm_timer_asserts (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .timer_output_pin_o(timer_output_pin_o), .timer_output_pin_oe_o(timer_output_pin_oe_o),
  .compare_a_flag_o(compare_a_flag_o), .compare_p_flag_o(compare_p_flag_o));

// File: testbench.sv
// Self-checking bench for ptm_timer: registers, compare, PWM, capture.
// Assumes ptm_pin_model at the pins; read data is scored by a monitor.
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ext_lvl = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000, r;
  logic [9:0] a;
  wire [31:0] dat_o;
  wire ack_o, pin_o, pin_oe, pin_in, ext_pin, flag_a, flag_p;
  int err_total = 0, total_checks = 0;
  logic [31:0] exp_q[$];
  // Rows: control, initial pin, pin after match, P flag, pin driven
  logic [11:0] cmp_tab[8] = '{12'h215, 12'h111, 12'h315, 12'h399, 12'h259, 12'h011, 12'h207, 12'hE02};
  always #10 clk_i = ~clk_i;
  ptm_timer u_ptm_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer_output_pin_i(pin_in), .timer_output_pin_o(pin_o), .timer_output_pin_oe_o(pin_oe),
    .external_clock_pin_i(ext_pin), .compare_a_flag_o(flag_a), .compare_p_flag_o(flag_p));
  ptm_pin_model u_ptm_pin_model (.pin_drv_i(pin_o), .pin_oe_i(pin_oe), .ext_lvl_i(ext_lvl),
    .pin_lvl_o(pin_in), .ext_pin_o(ext_pin));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    sel_i <= 4'hF;
    dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 50) err_total++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb(1'b0, ad, 8'h00);
  endtask
  task automatic wait_flag(input logic p);
    int k;
    k = 0;
    while ((p ? flag_p : flag_a) !== 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 3000) err_total++;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic cmp_run(input logic [11:0] t);
    a = 10'(4 + $urandom % 8);
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h20, 8'h03);
    wb(1'b1, 8'h04, t[11:4]);
    wb(1'b1, 8'h10, a[7:0]);
    wb(1'b1, 8'h14, 8'h00);
    wb(1'b1, 8'h18, t[1] ? a[7:0] + 8'h03 : 8'h02);
    wb(1'b1, 8'h1C, 8'h00);
    wb(1'b1, 8'h00, 8'h08);
    // Initial level reaches the pin two edges after the enable write
    repeat (2) @(posedge clk_i);
    #1;
    chk(pin_oe, t[0]);
    if (t[0]) chk(pin_o, t[3]);
    wait_flag(1'b0);
    if (t[0]) chk(pin_o, t[2]);
    if (t[1]) wait_flag(1'b1);
    chk(flag_p, t[1]);
  endtask
  task automatic pwm_run(input logic [7:0] c1, input logic [9:0] av, input logic [7:0] pv, input int n, input int e);
    int hi;
    hi = 0;
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h04, c1);
    wb(1'b1, 8'h10, av[7:0]);
    wb(1'b1, 8'h14, {6'h00, av[9:8]});
    wb(1'b1, 8'h18, pv);
    wb(1'b1, 8'h20, 8'h03);
    wb(1'b1, 8'h00, 8'h08);
    repeat (8) @(posedge clk_i);
    repeat (n) begin
      @(posedge clk_i);
      hi += (pin_o === 1'b1);
    end
    chk(hi, e);
    if (av < pv) chk({flag_a, flag_p}, 2'b11);
  endtask
  // ==========
  // Read scoring
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) chk(dat_o, exp_q.pop_front());
  end
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h60F4));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 8; i <= 28; i += 4) rd(8'(i), 32'h0);
    rd(8'h3C, 32'h0);
    wb(1'b1, 8'h08, 8'hFF);
    rd(8'h08, 32'h0);
    for (int j = 16; j <= 24; j += 8) begin
      r = $urandom;
      wb(1'b1, 8'(j), r[7:0]);
      wb(1'b1, 8'(j + 4), r[15:8]);
      rd(8'(j), {24'h0, r[7:0]});
      rd(8'(j + 4), {30'h0, r[9:8]});
    end
    for (int i = 0; i < 8; i++) cmp_run(cmp_tab[i]);
    pwm_run(8'hA9, 10'd2, 8'h05, 50, 20);
    pwm_run(8'hA8, 10'd6, 8'h05, 50, 50);
    pwm_run(8'h88, 10'd2, 8'h05, 50, 0);
    pwm_run(8'h98, 10'd2, 8'h05, 50, 50);
    pwm_run(8'hAC, 10'd2, 8'h05, 50, 30);
    pwm_run(8'hA8, 10'h200, 8'h00, 1024, 512);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'h00, 8'h00);
      wb(1'b1, 8'h20, 8'h03);
      wb(1'b1, 8'h04, i ? 8'h40 : 8'h42);
      wb(1'b1, 8'h00, 8'h08);
      repeat (4) @(posedge clk_i);
      ext_lvl <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_lvl <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(flag_a, i == 0);
    end
    chk(exp_q.size(), 0);
    report_and_stop();
  end
endmodule
